// [verilog/nvac_defs.vh]
// constants for the non-volatile store access controller
`ifndef NVAC_DEFS_VH
`define NVAC_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// register placement
`define NVAC_DIRECT_BANK  2'h0
`define NVAC_CTRL_BANK    2'h1
`define NVAC_ADDR_OFS     8'h1e
`define NVAC_DATA_OFS     8'h1f
`define NVAC_CTRL_OFS     8'h40

////////////////////////////////////////////////////////////////////////////////
// control register fields
`define NVAC_RD_BIT       0
`define NVAC_READ_PERMIT_BIT     1
`define NVAC_WR_BIT       2
`define NVAC_WRITE_PERMIT_BIT     3
`define NVAC_CTRL_RST     1'b0
`define NVAC_CTRL_PAD     4'h0

////////////////////////////////////////////////////////////////////////////////
// misc values
`define NVAC_ZERO8        8'h00
`define NVAC_ZERO16       16'h0000
`define NVAC_ONE16        16'h0001
`define NVAC_LFSR_SEED    8'ha5
`define NVAC_JITTER_PAD   12'h000

////////////////////////////////////////////////////////////////////////////////
// sequencer states
`define NVAC_ST_IDLE      2'h0
`define NVAC_ST_READ      2'h1
`define NVAC_ST_WRITE     2'h2

`endif

// [verilog/nvac_access_ctrl.v]
// byte-wide read and write sequencer for the internal non-volatile data store
//
// Functional notes
// (R01) single-byte access via address, data, control
// (R02) address 6 or 7 bits, upper zero
// (R03) control at 40h, bank one, indirect only
// (R04) address and data directly in bank zero
// (R05) write permit low inhibits all writes
// (R06) write trigger holds high until cycle ends
// (R07) write trigger ignored without prior permit
// (R08) read permit low inhibits all reads
// (R09) read trigger starts read, self-clears
// (R10) read trigger ignored without prior permit
// (R11) software never sets both triggers together
// (R12) fetched byte held until next operation
// (R13) software sets permit, address, then polls
// (R14) software loads address and data first
// (R15) software sets trigger right after permit
// (R16) software masks interrupts around write start
// (R17) write time from free-running asynchronous timer
// (R18) reset clears permits and triggers
// (R19) write end sets flag and shared flag
// (R20) data loaded when read trigger clears
`timescale 1ns/1ps
`include "nvac_defs.vh"

module nvac_access_ctrl #(
  parameter        ADDR_W      = 7,
  parameter [15:0] READ_CYCLES = 16'h0002,
  parameter [15:0] WRITE_MIN   = 16'h0040
) (
  input  wire       clock,
  input  wire       nrst,
  input  wire [1:0] bank_select,
  input  wire [7:0] sfr_addr,
  input  wire       sfr_indirect,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  input  wire       write_complete_clear,
  input  wire       shared_irq_serviced,
  output reg  [7:0] sfr_rdata,
  output reg        write_complete_flag,
  output reg        shared_irq_flag,
  output reg        nv_busy
);

  localparam DEPTH = 1 << ADDR_W;

  // state codes kept binary, one shared encoding
  localparam [1:0] ST_IDLE  = `NVAC_ST_IDLE;
  localparam [1:0] ST_READ  = `NVAC_ST_READ;
  localparam [1:0] ST_WRITE = `NVAC_ST_WRITE;

  ////////////////////////////////////////////////////////////////////////////
  // storage and registers

  reg  [7:0]        store [0:DEPTH-1];
  reg  [ADDR_W-1:0] nv_address;
  reg  [7:0]        nv_data;
  reg               write_permit;
  reg               write_trigger;
  reg               read_permit;
  reg               read_trigger;
  reg  [1:0]        state;
  reg  [15:0]       cnt;
  reg  [ADDR_W-1:0] op_addr;
  reg  [7:0]        op_data;
  reg  [7:0]        lfsr;
  reg               next_write_permit;
  reg               next_read_permit;
  reg               next_write_trigger;
  reg               next_read_trigger;
  reg  [1:0]        next_state;
  reg  [15:0]       next_cnt;
  reg               next_busy;
  reg               next_write_complete_flag;
  reg               next_shared_irq_flag;
  reg  [7:0]        next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire direct_bank = (bank_select == `NVAC_DIRECT_BANK) && !sfr_indirect;
  wire hit_addr    = direct_bank && (sfr_addr == `NVAC_ADDR_OFS);    // [R04]
  wire hit_data    = direct_bank && (sfr_addr == `NVAC_DATA_OFS);    // [R04]
  // control is only visible through the indirect pointer, bank one
  wire hit_ctrl    = sfr_indirect && (bank_select == `NVAC_CTRL_BANK)
                     && (sfr_addr == `NVAC_CTRL_OFS);                 // [R03]

  wire ctrl_wr     = sfr_wr && hit_ctrl;
  wire new_wr_trig = sfr_wdata[`NVAC_WR_BIT];
  wire new_rd_trig = sfr_wdata[`NVAC_RD_BIT];

  // permits are taken from the stored bit, so a permit and trigger
  // written by one access do not start anything
  wire start_write = ctrl_wr && new_wr_trig && write_permit
                     && (state == ST_IDLE);                           // [R07]
  wire start_read  = ctrl_wr && new_rd_trig && read_permit
                     && (state == ST_IDLE) && !start_write;           // [R10] [R08]

  wire [7:0] addr_byte = {{(8-ADDR_W){1'b0}}, nv_address};           // [R02]
  wire [7:0] ctrl_byte = {`NVAC_CTRL_PAD, write_permit, write_trigger,
                          read_permit, read_trigger};

  wire cnt_done   = (cnt == `NVAC_ONE16);
  wire write_end  = (state == ST_WRITE) && cnt_done;
  wire read_end   = (state == ST_READ) && cnt_done;

  // a permit dropped mid-cycle still blocks the final transfer
  wire store_commit = write_end && write_permit;                      // [R05]
  wire fetch_commit = read_end && read_permit;                        // [R08]

  // jitter stands in for the asynchronous write timer
  wire [15:0] write_len = WRITE_MIN + {`NVAC_JITTER_PAD, lfsr[3:0]};  // [R17]

  ////////////////////////////////////////////////////////////////////////////
  // free-running timer source

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lfsr <= `NVAC_LFSR_SEED;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};    // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  always @* begin
    next_write_permit  = write_permit;
    next_read_permit   = read_permit;
    next_write_trigger = write_trigger;
    next_read_trigger  = read_trigger;
    if (ctrl_wr) begin
      next_write_permit = sfr_wdata[`NVAC_WRITE_PERMIT_BIT];                  // [R05]
      next_read_permit  = sfr_wdata[`NVAC_READ_PERMIT_BIT];                  // [R08]
    end
    // triggers are set only by an accepted start, cleared only here
    if (start_write) begin
      next_write_trigger = 1'h1;                                      // [R06]
    end else if (write_end) begin
      next_write_trigger = 1'h0;                                      // [R06]
    end
    if (start_read) begin
      next_read_trigger = 1'h1;                                       // [R09]
    end else if (read_end) begin
      next_read_trigger = 1'h0;                                       // [R09] [R20]
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      write_permit  <= `NVAC_CTRL_RST;                                // [R18]
      read_permit   <= `NVAC_CTRL_RST;                                // [R18]
      write_trigger <= `NVAC_CTRL_RST;                                // [R18]
      read_trigger  <= `NVAC_CTRL_RST;                                // [R18]
    end else begin
      write_permit  <= next_write_permit;
      read_permit   <= next_read_permit;
      write_trigger <= next_write_trigger;
      read_trigger  <= next_read_trigger;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // busy and the triggers move on the same edges, so they always agree
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    next_busy  = nv_busy;
    case (state)
      ST_IDLE: begin
        if (start_write) begin
          next_state = ST_WRITE;
          next_cnt   = write_len;                                     // [R17]
          next_busy  = 1'h1;
        end else if (start_read) begin
          next_state = ST_READ;
          next_cnt   = READ_CYCLES;                                   // [R09]
          next_busy  = 1'h1;
        end
      end
      ST_READ, ST_WRITE: begin
        if (cnt_done) begin
          next_state = ST_IDLE;
          next_cnt   = `NVAC_ZERO16;
          next_busy  = 1'h0;
        end else begin
          next_cnt = cnt - `NVAC_ONE16;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt   = `NVAC_ZERO16;
        next_busy  = 1'h0;
      end
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state   <= ST_IDLE;
      cnt     <= `NVAC_ZERO16;
      nv_busy <= 1'h0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      nv_busy <= next_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address, data and operand latch

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nv_address <= {ADDR_W{1'b0}};
      nv_data    <= `NVAC_ZERO8;
      op_addr    <= {ADDR_W{1'b0}};
      op_data    <= `NVAC_ZERO8;
    end else begin
      if (sfr_wr && hit_addr) begin
        nv_address <= sfr_wdata[ADDR_W-1:0];                          // [R02]
      end
      // completing read wins over a same-cycle software write
      if (fetch_commit) begin
        nv_data <= store[op_addr];                                    // [R12] [R20] [R08]
      end else if (sfr_wr && hit_data) begin
        nv_data <= sfr_wdata;
      end
      // operands frozen at start so a cycle in flight is not disturbed
      if (start_write || start_read) begin
        op_addr <= nv_address;                                        // [R01]
        op_data <= nv_data;                                           // [R01]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // store array, no reset: contents survive power loss

  always @(posedge clock) begin
    // dropping the write permit mid-cycle abandons the store
    if (store_commit) begin
      store[op_addr] <= op_data;                                      // [R05] [R01]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion flags, set beats clear

  // servicing clears only the shared flag; software clears its own
  always @* begin
    next_write_complete_flag = write_complete_flag;
    next_shared_irq_flag     = shared_irq_flag;
    if (write_complete_clear) begin
      next_write_complete_flag = 1'h0;                                // [R19]
    end
    if (shared_irq_serviced) begin
      next_shared_irq_flag = 1'h0;                                    // [R19]
    end
    if (write_end) begin
      next_write_complete_flag = 1'h1;                                // [R19]
      next_shared_irq_flag     = 1'h1;                                // [R19]
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      write_complete_flag <= 1'h0;
      shared_irq_flag     <= 1'h0;
    end else begin
      write_complete_flag <= next_write_complete_flag;
      shared_irq_flag     <= next_shared_irq_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back port

  // read data registered so it stands until the next read strobe
  always @* begin
    next_rdata = sfr_rdata;
    if (sfr_rd) begin
      if (hit_addr) begin
        next_rdata = addr_byte;                                       // [R02]
      end else if (hit_data) begin
        next_rdata = nv_data;                                         // [R12]
      end else if (hit_ctrl) begin
        next_rdata = ctrl_byte;                                       // [R03]
      end else begin
        next_rdata = `NVAC_ZERO8;
      end
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= `NVAC_ZERO8;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end

endmodule // nvac_access_ctrl

// [testbench/nvac_access_ctrl_assertions.sv]
// port checker for the access controller
`timescale 1ns/1ps
module nvac_access_ctrl_checker #(
  parameter        ADDR_W      = 7,
  parameter [15:0] READ_CYCLES = 16'h0002,
  parameter [15:0] WRITE_MIN   = 16'h0040
) (
  input wire       clock,
  input wire       nrst,
  input wire [1:0] bank_select,
  input wire [7:0] sfr_addr,
  input wire       sfr_indirect,
  input wire       sfr_wr,
  input wire       sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire       write_complete_clear,
  input wire       shared_irq_serviced,
  input wire [7:0] sfr_rdata,
  input wire       write_complete_flag,
  input wire       shared_irq_flag,
  input wire       nv_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire ctrl_hit;
  assign ctrl_hit = sfr_indirect && (bank_select == 2'h1) && (sfr_addr == 8'h40);
  // lengths below assume default read count and a write minimum of 8
  sequence rd_start;
    sfr_wr && ctrl_hit && sfr_wdata[0] && !nv_busy ##1 $rose(nv_busy);
  endsequence
  sequence wr_start;
    sfr_wr && ctrl_hit && sfr_wdata[2] && !nv_busy ##1 $rose(nv_busy);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  busy_cause_a: assert property ($rose(nv_busy) |->
    $past(sfr_wr && ctrl_hit && (sfr_wdata[0] || sfr_wdata[2]))) else $error("busy without trigger");
  read_len_a: assert property (rd_start |=> nv_busy ##1 !nv_busy)
    else $error("read cycle length wrong");
  write_len_a: assert property (wr_start |=> nv_busy[*7] ##[1:16] !nv_busy)
    else $error("write cycle length wrong");
  flag_at_end_a: assert property ($rose(write_complete_flag) |-> $fell(nv_busy))
    else $error("flag set outside write end");
  shared_pair_a: assert property ($rose(shared_irq_flag) |-> write_complete_flag && $fell(nv_busy))
    else $error("shared flag without write flag");
  flag_sticky_a: assert property (write_complete_flag && !write_complete_clear |=> write_complete_flag)
    else $error("write flag dropped by itself");
  flag_clear_a: assert property (write_complete_clear && !nv_busy |=> !write_complete_flag)
    else $error("write flag not cleared");
  trig_view_a: assert property (sfr_rd && ctrl_hit |=>
    ((sfr_rdata[2] || sfr_rdata[0]) == $past(nv_busy)) && (sfr_rdata[7:4] == 4'h0)) else $error("trigger view wrong");
  addr_width_a: assert property (sfr_rd && !sfr_indirect && bank_select == 2'h0 && sfr_addr == 8'h1e
    |=> (sfr_rdata >> ADDR_W) == 8'h00) else $error("address upper bits set");
endmodule // nvac_access_ctrl_checker

bind nvac_access_ctrl nvac_access_ctrl_checker #(.ADDR_W(ADDR_W), .READ_CYCLES(READ_CYCLES),
  .WRITE_MIN(WRITE_MIN)) chk_i (.clock(clock), .nrst(nrst), .bank_select(bank_select),
  .sfr_addr(sfr_addr), .sfr_indirect(sfr_indirect), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .write_complete_clear(write_complete_clear),
  .shared_irq_serviced(shared_irq_serviced), .sfr_rdata(sfr_rdata),
  .write_complete_flag(write_complete_flag), .shared_irq_flag(shared_irq_flag), .nv_busy(nv_busy));

// [testbench/nvac_access_ctrl_test.sv]
// self-checking bench for the access controller
`timescale 1ns/1ps
module nvac_access_ctrl_test;
  reg        clock, nrst, sfr_indirect, sfr_wr, sfr_rd, wc_clear, irq_done;
  reg  [1:0] bank_select;
  reg  [7:0] sfr_addr, sfr_wdata;
  wire [7:0] sfr_rdata;
  wire       write_complete_flag, shared_irq_flag, nv_busy;
  integer    num_errors = 0, compares = 0, i, n;
  reg [26:0] rows [0:8]; // bank, indirect, address, write value, readback
  nvac_access_ctrl #(.WRITE_MIN(16'h0008)) uut (.clock(clock), .nrst(nrst),
    .bank_select(bank_select), .sfr_addr(sfr_addr), .sfr_indirect(sfr_indirect),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .write_complete_clear(wc_clear),
    .shared_irq_serviced(irq_done), .sfr_rdata(sfr_rdata), .write_complete_flag(write_complete_flag),
    .shared_irq_flag(shared_irq_flag), .nv_busy(nv_busy));
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [7:0] seen, input [7:0] exp); begin
    compares = compares + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  end endtask
  // extra idle cycle at the end so read data has settled
  task acc(input w, input [1:0] b, input ind, input [7:0] a, input [7:0] d); begin
    @(posedge clock) #1;
    sfr_wr = w;
    sfr_rd = !w;
    bank_select = b;
    sfr_indirect = ind;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clock) #1;
    sfr_wr = 0;
    sfr_rd = 0;
    @(posedge clock) #1;
  end endtask
  task ctl(input [7:0] d); acc(1, 2'h1, 1, 8'h40, d); endtask
  task rctl; acc(0, 2'h1, 1, 8'h40, 8'h00); endtask
  task wait_idle; begin
    n = 0;
    while (nv_busy !== 1'b0 && n < 100) begin
      @(posedge clock) #1;
      n = n + 1;
    end
    chk(n < 100, 8'h01);
  end endtask
  task conclude; begin
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    {nrst, sfr_indirect, sfr_wr, sfr_rd, wc_clear, irq_done, bank_select} = 8'h00;
    {sfr_addr, sfr_wdata} = 16'h0000;
    rows[0] = {2'h0, 1'b0, 8'h1e, 8'hff, 8'h7f};
    rows[1] = {2'h0, 1'b0, 8'h1f, 8'ha5, 8'ha5};
    rows[2] = {2'h0, 1'b0, 8'h40, 8'h0a, 8'h00};
    rows[3] = {2'h0, 1'b1, 8'h40, 8'h0a, 8'h00};
    rows[4] = {2'h1, 1'b1, 8'h40, 8'h05, 8'h00};
    rows[5] = {2'h1, 1'b1, 8'h40, 8'h0c, 8'h08};
    rows[6] = {2'h1, 1'b1, 8'h40, 8'h03, 8'h02};
    rows[7] = {2'h1, 1'b1, 8'h40, 8'hf0, 8'h00};
    rows[8] = {2'h0, 1'b0, 8'h20, 8'h5a, 8'h00};
    repeat (4) @(posedge clock);
    #1 nrst = 1;
    chk({5'h00, write_complete_flag, shared_irq_flag, nv_busy}, 8'h00);
    rctl;
    chk(sfr_rdata, 8'h00);
    for (i = 0; i < 9; i = i + 1) begin
      acc(1, rows[i][26:25], rows[i][24], rows[i][23:16], rows[i][15:8]);
      acc(0, rows[i][26:25], rows[i][24], rows[i][23:16], 8'h00);
      chk(sfr_rdata, rows[i][7:0]);
      chk({7'h00, nv_busy}, 8'h00);
    end
    acc(1, 2'h0, 0, 8'h1e, 8'h05);
    acc(1, 2'h0, 0, 8'h1f, 8'h3c);
    ctl(8'h08);
    ctl(8'h0c);
    rctl;
    chk(sfr_rdata, 8'h0c);
    wait_idle;
    chk({6'h00, write_complete_flag, shared_irq_flag}, 8'h03);
    rctl;
    chk(sfr_rdata, 8'h08);
    @(posedge clock) #1 {wc_clear, irq_done} = 2'h3;
    @(posedge clock) #1 {wc_clear, irq_done} = 2'h0;
    chk({6'h00, write_complete_flag, shared_irq_flag}, 8'h00);
    // dropping the permit mid-write must abandon the store
    acc(1, 2'h0, 0, 8'h1f, 8'h99);
    ctl(8'h08);
    ctl(8'h0c);
    ctl(8'h00);
    wait_idle;
    chk({6'h00, write_complete_flag, shared_irq_flag}, 8'h03);
    ctl(8'h02);
    acc(1, 2'h0, 0, 8'h1f, 8'h00);
    ctl(8'h03);
    wait_idle;
    acc(0, 2'h0, 0, 8'h1f, 8'h00);
    chk(sfr_rdata, 8'h3c);
    repeat (5) @(posedge clock);
    acc(0, 2'h0, 0, 8'h1f, 8'h00);
    chk(sfr_rdata, 8'h3c);
    rctl;
    chk(sfr_rdata, 8'h02);
    conclude;
  end
endmodule // nvac_access_ctrl_test
